// ### imu_status_pkg.sv
// Package: register offsets, field layouts, codes and carrier structs for the status block
package imu_status_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FEATURE_EVENT = 8'h1C;
  localparam logic [7:0] OFS_SYSTEM_EVENT = 8'h1D;
  localparam logic [7:0] OFS_STEP_LOW = 8'h1E;
  localparam logic [7:0] OFS_STEP_HIGH = 8'h1F;
  localparam logic [7:0] OFS_GEST_ACT = 8'h20;
  localparam logic [7:0] OFS_INTERNAL = 8'h21;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h40;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h41;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h42;
  localparam logic [7:0] OFS_REMAP = 8'h43;
  localparam logic [7:0] OFS_RATE_CFG = 8'h44;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_STEP = 16'h0000;
  localparam logic [7:0] FEATURE_MASK = 8'h7F;
  localparam logic [7:0] SYSTEM_MASK = 8'hE7;
  localparam int BIT_REMAP_ERR = 5;
  localparam int BIT_RATE_ERR = 6;
  localparam logic [3:0] RATE_MIN_50HZ = 4'h5;
  localparam logic [5:0] RST_REMAP = 6'h24;
  localparam logic [3:0] RST_RATE = 4'h8;
  localparam logic [1:0] IRQ_FEATURE = 2'h1;
  localparam logic [1:0] IRQ_SYSTEM = 2'h2;
  localparam int SERIAL_BITS = 8;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    GEST_UNKNOWN = 3'h0, GEST_PUSH_DOWN = 3'h1, GEST_PIVOT_UP = 3'h2,
    GEST_SHAKE = 3'h3, GEST_FLICK_IN = 3'h4, GEST_FLICK_OUT = 3'h5
  } gesture_t;
  typedef enum logic [1:0] {
    ACT_STILL = 2'h0, ACT_WALKING = 2'h1, ACT_RUNNING = 2'h2, ACT_UNKNOWN = 2'h3
  } activity_t;
  typedef enum logic [3:0] {
    MSG_NOT_INIT = 4'h0, MSG_INIT_OK = 4'h1, MSG_INIT_ERR = 4'h2, MSG_DRV_ERR = 4'h3,
    MSG_SNS_STOP = 4'h4, MSG_NVM_ERR = 4'h5, MSG_START_ERR = 4'h6, MSG_COMPAT_ERR = 4'h7
  } message_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [6:0] feature;
    logic [5:0] system;
  } event_pulses_t;

  typedef struct packed {
    logic init_done;
    logic [2:0] gesture;
    logic [1:0] activity;
    logic result_valid;
    logic [15:0] steps;
    logic msg_valid;
    logic [3:0] message;
  } engine_result_t;

endpackage

// ### imu_sync3.sv
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
`default_nettype none
module imu_sync3 (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_async,
  output logic o_level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level changes only once stages two and three agree
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_level <= 1'b0;
    end else if (s2_q == s3_q) begin
      o_level <= s3_q;
    end
  end
endmodule
`default_nettype wire

// ### imu_remap_check.sv
// Axis remap and feature rate fault checker
`timescale 1ns/1ps
`default_nettype none
module imu_remap_check (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [5:0] i_remap,
  input wire logic [3:0] i_rate,
  input wire logic i_needs_50hz,
  output logic o_remap_fault,
  output logic o_feature_rate_fault
);
  wire [1:0] map_x = i_remap[1:0];
  wire [1:0] map_y = i_remap[3:2];
  wire [1:0] map_z = i_remap[5:4];
  wire dup = (map_x == map_y) || (map_x == map_z) || (map_y == map_z);
  wire slow = i_needs_50hz && (i_rate < imu_status_pkg::RATE_MIN_50HZ);

  // Register both faults
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_remap_fault <= 1'b0;
      o_feature_rate_fault <= 1'b0;
    end else begin
      o_remap_fault <= dup; // see R11
      o_feature_rate_fault <= slow; // see R12
    end
  end
endmodule
`default_nettype wire

// ### imu_status_result_regs.sv
// Status and result register bank of the motion sensor
// Functional notes
// R1 - Feature event flags clear on read, reset zero
// R2 - System flags clear after bit 0 shifted
// R3 - Feature bits 0..6 per event, bit7 zero
// R4 - System bits 0,1,2,5,6,7 per event
// R5 - System bits 3 and 4 read zero
// R6 - Step count low/high bytes, reset zero
// R7 - Gesture code in bits 2:0
// R8 - Gesture reads unknown after init
// R9 - Activity in bits 4:3, unknown after init
// R10 - Status message in bits 3:0
// R11 - Bit 5 flags duplicate axis remap
// R12 - Bit 6 flags too slow feature rate
// R13 - Bits 4,7 zero, register resets zero
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module imu_status_result_regs (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_bit0_shifted,
  input wire logic [6:0] i_feature_evt,
  input wire logic [5:0] i_system_evt,
  input wire logic i_init_done,
  input wire logic [2:0] i_gesture,
  input wire logic [1:0] i_activity,
  input wire logic i_result_valid,
  input wire logic [15:0] i_steps,
  input wire logic i_msg_valid,
  input wire logic [3:0] i_message,
  input wire logic i_needs_50hz,
  input wire logic i_stop_pin,
  output logic [7:0] o_rdata,
  output logic o_irq
);
  imu_status_pkg::reg_req_t req;
  imu_status_pkg::event_pulses_t evt;
  imu_status_pkg::engine_result_t res;

  logic [7:0] feat_q;
  logic [7:0] sys_q;
  logic [15:0] step_q;
  logic [2:0] gest_q;
  logic [1:0] act_q;
  logic [3:0] msg_q;
  logic [5:0] remap_q;
  logic [3:0] rate_q;
  logic [1:0] irq_en_q;
  logic [1:0] irq_st_q;
  logic sys_rd_pend_q;
  logic [7:0] sys_seen_q;
  logic [7:0] rdata_d;
  logic remap_fault;
  logic rate_fault;
  logic stop_level;

  // ----------------------------------------------------------------
  // Bundling
  // ----------------------------------------------------------------
  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign evt = '{feature: i_feature_evt, system: i_system_evt};
  assign res = '{init_done: i_init_done, gesture: i_gesture, activity: i_activity,
                 result_valid: i_result_valid, steps: i_steps,
                 msg_valid: i_msg_valid, message: i_message};

  // Address hit helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire rd_feat = req.rd && hit(req.addr, imu_status_pkg::OFS_FEATURE_EVENT);
  wire rd_sys = req.rd && hit(req.addr, imu_status_pkg::OFS_SYSTEM_EVENT);
  wire wr_en = req.wr && hit(req.addr, imu_status_pkg::OFS_IRQ_ENABLE);
  wire wr_clr = req.wr && hit(req.addr, imu_status_pkg::OFS_IRQ_CLEAR);
  wire wr_remap = req.wr && hit(req.addr, imu_status_pkg::OFS_REMAP);
  wire wr_rate = req.wr && hit(req.addr, imu_status_pkg::OFS_RATE_CFG);
  // System flags are cleared only when bit 0 has left the serial shifter
  wire sys_clear = sys_rd_pend_q && i_bit0_shifted; // see R2
  wire [7:0] feat_set = {1'b0, evt.feature}; // see R3
  wire [7:0] sys_set = {evt.system[5:3], 2'b00, evt.system[2:0]}; // see R4, see R5
  wire [7:0] internal_rd = {1'b0, rate_fault, remap_fault, 1'b0, msg_q}; // see R13
  wire [7:0] feat_next = ((rd_feat ? 8'h00 : feat_q) | feat_set) & imu_status_pkg::FEATURE_MASK;
  // Only flags the pending read reported are dropped; later events survive
  wire [7:0] sys_drop = sys_clear ? sys_seen_q : 8'h00; // see R2
  wire [7:0] sys_next = ((sys_q & ~sys_drop) | sys_set) & imu_status_pkg::SYSTEM_MASK;
  // Any other read strobe abandons a partial read of the system flags
  wire sys_rd_pend_d = req.rd ? rd_sys : (i_bit0_shifted ? 1'b0 : sys_rd_pend_q); // see R2
  wire [1:0] irq_set = {|sys_set, |feat_set};
  wire [1:0] irq_next = (irq_st_q & ~(wr_clr ? req.wdata[1:0] : 2'b00)) | irq_set;

  // Read mux, unmapped offsets read zero
  always_comb begin
    rdata_d = 8'h00;
    case (req.addr)
      imu_status_pkg::OFS_FEATURE_EVENT: rdata_d = feat_q; // see R1
      imu_status_pkg::OFS_SYSTEM_EVENT: rdata_d = sys_q;
      imu_status_pkg::OFS_STEP_LOW: rdata_d = step_q[7:0]; // see R6
      imu_status_pkg::OFS_STEP_HIGH: rdata_d = step_q[15:8];
      imu_status_pkg::OFS_GEST_ACT: rdata_d = {3'b000, act_q, gest_q}; // see R7, see R9
      imu_status_pkg::OFS_INTERNAL: rdata_d = internal_rd; // see R10
      imu_status_pkg::OFS_IRQ_ENABLE: rdata_d = {6'h00, irq_en_q};
      imu_status_pkg::OFS_IRQ_STATUS: rdata_d = {6'h00, irq_st_q};
      imu_status_pkg::OFS_REMAP: rdata_d = {2'b00, remap_q};
      imu_status_pkg::OFS_RATE_CFG: rdata_d = {4'h0, rate_q};
      default: rdata_d = 8'h00;
    endcase
    if (!req.rd) begin
      rdata_d = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  imu_remap_check u_check (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_remap(remap_q),
    .i_rate(rate_q),
    .i_needs_50hz(i_needs_50hz),
    .o_remap_fault(remap_fault),
    .o_feature_rate_fault(rate_fault)
  );

  imu_sync3 u_stop (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_async(i_stop_pin),
    .o_level(stop_level)
  );

  // ----------------------------------------------------------------
  // Event flags; a set in the clearing cycle wins
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      feat_q <= imu_status_pkg::RST_BYTE;
      sys_q <= imu_status_pkg::RST_BYTE;
      sys_rd_pend_q <= 1'b0;
      sys_seen_q <= imu_status_pkg::RST_BYTE;
    end else begin
      feat_q <= feat_next; // see R1
      sys_q <= sys_next; // see R2
      sys_rd_pend_q <= sys_rd_pend_d;
      if (rd_sys) begin
        sys_seen_q <= sys_q;
      end
    end
  end

  // Results from the feature engines
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      step_q <= imu_status_pkg::RST_STEP;
      gest_q <= 3'b000;
      act_q <= 2'b00;
    end else if (res.result_valid) begin
      step_q <= res.steps; // see R6
      gest_q <= res.gesture; // see R7
      act_q <= res.activity; // see R9
    end else if (res.init_done) begin
      gest_q <= imu_status_pkg::GEST_UNKNOWN; // see R8
      act_q <= imu_status_pkg::ACT_UNKNOWN; // see R9
    end
  end

  // Status message; stop pin overrides to sensor stopped
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      msg_q <= imu_status_pkg::MSG_NOT_INIT; // see R13
    end else if (stop_level) begin
      msg_q <= imu_status_pkg::MSG_SNS_STOP;
    end else if (res.msg_valid) begin
      msg_q <= res.message; // see R10
    end
  end

  // Software configuration and interrupt control
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      remap_q <= imu_status_pkg::RST_REMAP;
      rate_q <= imu_status_pkg::RST_RATE;
      irq_en_q <= 2'b00;
      irq_st_q <= 2'b00;
    end else begin
      if (wr_remap) begin
        remap_q <= req.wdata[5:0];
      end
      if (wr_rate) begin
        rate_q <= req.wdata[3:0];
      end
      if (wr_en) begin
        irq_en_q <= req.wdata[1:0];
      end
      irq_st_q <= irq_next;
    end
  end

  // Registered outputs
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
      o_irq <= 1'b0;
    end else begin
      o_rdata <= rdata_d;
      o_irq <= |(irq_next & irq_en_q);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_feat_clear;
    @(posedge i_clk) disable iff (!i_rstn)
      rd_feat && (evt.feature == 7'h00) |=> (feat_q == 8'h00);
  endproperty
  a_feat_clear: assert property (p_feat_clear) else $error("feature flags not cleared"); // see R1

  property p_sys_hold;
    @(posedge i_clk) disable iff (!i_rstn)
      rd_sys && !i_bit0_shifted |=> (sys_q & $past(sys_q)) == $past(sys_q);
  endproperty
  a_sys_hold: assert property (p_sys_hold) else $error("system flags lost early"); // see R2

  property p_feat_set;
    @(posedge i_clk) disable iff (!i_rstn)
      evt.feature[0] |=> feat_q[0] && !feat_q[7];
  endproperty
  a_feat_set: assert property (p_feat_set) else $error("feature flag not set"); // see R3

  property p_sys_set;
    @(posedge i_clk) disable iff (!i_rstn)
      evt.system[5] |=> sys_q[7];
  endproperty
  a_sys_set: assert property (p_sys_set) else $error("accel ready not set"); // see R4

  property p_sys_resv;
    @(posedge i_clk) disable iff (!i_rstn)
      rd_sys |=> o_rdata[4:3] == 2'b00;
  endproperty
  a_sys_resv: assert property (p_sys_resv) else $error("reserved system bits set"); // see R5

  property p_step_read;
    @(posedge i_clk) disable iff (!i_rstn)
      req.rd && hit(req.addr, imu_status_pkg::OFS_STEP_HIGH) |=> o_rdata == $past(step_q[15:8]);
  endproperty
  a_step_read: assert property (p_step_read) else $error("step high byte wrong"); // see R6

  property p_gest_init;
    @(posedge i_clk) disable iff (!i_rstn)
      res.init_done && !res.result_valid |=> gest_q == 3'b000 && act_q == 2'b11;
  endproperty
  a_gest_init: assert property (p_gest_init) else $error("init result not unknown"); // see R8

  property p_internal;
    @(posedge i_clk) disable iff (!i_rstn)
      req.rd && hit(req.addr, imu_status_pkg::OFS_INTERNAL) |=> !o_rdata[7] && !o_rdata[4];
  endproperty
  a_internal: assert property (p_internal) else $error("internal reserved bits set"); // see R13

  property p_sys_set_wins;
    @(posedge i_clk) disable iff (!i_rstn)
      evt.system != 6'h00 |=> (sys_q & $past(sys_set)) == $past(sys_set);
  endproperty
  a_sys_set_wins: assert property (p_sys_set_wins) else $error("system flag lost"); // see R4

  property p_sys_clear;
    @(posedge i_clk) disable iff (!i_rstn)
      sys_clear && (evt.system == 6'h00) |=> (sys_q & $past(sys_seen_q)) == 8'h00;
  endproperty
  a_sys_clear: assert property (p_sys_clear) else $error("system flags not cleared"); // see R2

  property p_step_low;
    @(posedge i_clk) disable iff (!i_rstn)
      req.rd && hit(req.addr, imu_status_pkg::OFS_STEP_LOW) |=> o_rdata == $past(step_q[7:0]);
  endproperty
  a_step_low: assert property (p_step_low) else $error("step low byte wrong"); // see R6

  property p_result_load;
    @(posedge i_clk) disable iff (!i_rstn)
      res.result_valid |=> gest_q == $past(res.gesture) && act_q == $past(res.activity);
  endproperty
  a_result_load: assert property (p_result_load) else $error("result not loaded"); // see R7

  property p_msg_load;
    @(posedge i_clk) disable iff (!i_rstn)
      res.msg_valid && !stop_level |=> msg_q == $past(res.message);
  endproperty
  a_msg_load: assert property (p_msg_load) else $error("status message not loaded"); // see R10

  property p_remap_fault;
    @(posedge i_clk) disable iff (!i_rstn)
      (remap_q[1:0] == remap_q[3:2]) |=> remap_fault;
  endproperty
  a_remap_fault: assert property (p_remap_fault) else $error("remap fault missing"); // see R11

  property p_rate_fault;
    @(posedge i_clk) disable iff (!i_rstn)
      i_needs_50hz && (rate_q < imu_status_pkg::RATE_MIN_50HZ) |=> rate_fault;
  endproperty
  a_rate_fault: assert property (p_rate_fault) else $error("rate fault missing"); // see R12

  property p_stop;
    @(posedge i_clk) disable iff (!i_rstn)
      stop_level |=> msg_q == imu_status_pkg::MSG_SNS_STOP;
  endproperty
  a_stop: assert property (p_stop) else $error("stop message missing");
endmodule
`default_nettype wire

// ### imu_host_model.sv
// Host model: register bus master that notes the expected read data
`timescale 1ns/1ps
`default_nettype none
module imu_host_model (
  input wire logic i_clk,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  output logic o_bit0_shifted
);
  logic [7:0] exp_q[$];
  // Idle bus at time zero
  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'h0;
    o_rd = 1'h0;
    o_bit0_shifted = 1'h0;
  end
  // One write cycle; released lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'h1;
    @(posedge i_clk);
    o_wr <= 1'h0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  // One read cycle; sh marks bit 0 shifted out during the data cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic sh);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'h1;
    exp_q.push_back(e);
    @(posedge i_clk);
    o_rd <= 1'h0;
    o_addr <= ~a;
    o_bit0_shifted <= sh;
    @(posedge i_clk);
    o_bit0_shifted <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ### imu_status_result_regs_tb.sv
// Self-checking testbench of the status and result register bank
`timescale 1ns/1ps
`default_nettype none
module imu_status_result_regs_tb;
  logic i_clk = 1'h0;
  logic rstn = 1'h0;
  logic [6:0] fevt = 7'h00;
  logic [5:0] sevt = 6'h00;
  logic init = 1'h0;
  logic [2:0] gest = 3'h0;
  logic [1:0] act = 2'h0;
  logic rv = 1'h0;
  logic [15:0] steps = 16'h0000;
  logic mv = 1'h0;
  logic [3:0] msg = 4'h0;
  logic n50 = 1'h0;
  logic stop = 1'h0;
  logic pend = 1'h0;
  logic [7:0] expv;
  logic [7:0] rdata;
  logic irq;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic b0;
  logic [31:0] seed = 32'h0B56;
  logic [7:0] smap [6] = '{8'h01, 8'h02, 8'h04, 8'h20, 8'h40, 8'h80};
  int n_mismatch = 0;
  int check_count = 0;

  // Clock at 100 MHz
  initial begin
    forever #5 i_clk = ~i_clk;
  end

  imu_host_model host (.i_clk(i_clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
    .o_bit0_shifted(b0));

  imu_status_result_regs DUT (
    .i_clk(i_clk),
    .i_rstn(rstn),
    .i_addr(addr),
    .i_wdata(wdata),
    .i_wr(wr),
    .i_rd(rd),
    .i_bit0_shifted(b0),
    .i_feature_evt(fevt),
    .i_system_evt(sevt),
    .i_init_done(init),
    .i_gesture(gest),
    .i_activity(act),
    .i_result_valid(rv),
    .i_steps(steps),
    .i_msg_valid(mv),
    .i_message(msg),
    .i_needs_50hz(n50),
    .i_stop_pin(stop),
    .o_rdata(rdata),
    .o_irq(irq)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] e);
    check_count++;
    if (got !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  task automatic pulse_evt(input logic [6:0] f, input logic [5:0] s);
    @(posedge i_clk);
    fevt <= f;
    sevt <= s;
    @(posedge i_clk);
    fevt <= 7'h00;
    sevt <= 6'h00;
  endtask
  task automatic load(input logic [15:0] s, input logic [2:0] g, input logic [1:0] a);
    @(posedge i_clk);
    steps <= s;
    gest <= g;
    act <= a;
    rv <= 1'h1;
    @(posedge i_clk);
    rv <= 1'h0;
  endtask
  task automatic chk_irq(input logic e);
    repeat (2) @(posedge i_clk);
    #1;
    chk({7'h00, irq}, {7'h00, e});
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Read data stands in the cycle after the strobe: oldest note is compared
  always @(posedge i_clk) begin
    if (pend) begin
      expv = host.exp_q.pop_front();
      chk(rdata, expv);
    end
    pend <= rd;
  end

  // Watchdog
  initial begin
    #50us;
    n_mismatch++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge i_clk);
    rstn <= 1'h1;
    for (int i = 0; i < 6; i++) begin
      host.rd(imu_status_pkg::OFS_FEATURE_EVENT + 8'(i), imu_status_pkg::RST_BYTE, 1'h0);
    end
    host.rd(8'h30, 8'h00, 1'h0);
    $display("test reset values done");
    for (int i = 0; i < 7; i++) begin
      pulse_evt(7'h01 << i, 6'h00);
      host.rd(imu_status_pkg::OFS_FEATURE_EVENT, 8'(1 << i), 1'h0);
      host.rd(imu_status_pkg::OFS_FEATURE_EVENT, 8'h00, 1'h0);
    end
    pulse_evt(7'h7F, 6'h00);
    host.rd(imu_status_pkg::OFS_FEATURE_EVENT, 8'h7F, 1'h0);
    $display("test feature flags done");
    for (int i = 0; i < 6; i++) begin
      pulse_evt(7'h00, 6'h01 << i);
      host.rd(imu_status_pkg::OFS_SYSTEM_EVENT, smap[i], 1'h0);
      host.rd(imu_status_pkg::OFS_SYSTEM_EVENT, smap[i], 1'h1);
      host.rd(imu_status_pkg::OFS_SYSTEM_EVENT, 8'h00, 1'h0);
    end
    pulse_evt(7'h00, 6'h3F);
    host.rd(imu_status_pkg::OFS_SYSTEM_EVENT, 8'hE7, 1'h0);
    host.rd(imu_status_pkg::OFS_FEATURE_EVENT, 8'h00, 1'h1);
    host.rd(imu_status_pkg::OFS_SYSTEM_EVENT, 8'hE7, 1'h1);
    host.rd(imu_status_pkg::OFS_SYSTEM_EVENT, 8'h00, 1'h0);
    $display("test system flags done");
    @(posedge i_clk);
    init <= 1'h1;
    @(posedge i_clk);
    init <= 1'h0;
    host.rd(imu_status_pkg::OFS_GEST_ACT, 8'h18, 1'h0);
    for (int g = 0; g < 6; g++) begin
      seed = lfsr(seed);
      load(seed[15:0], 3'(g), 2'(g));
      host.wr(imu_status_pkg::OFS_STEP_LOW, ~seed[7:0]);
      host.rd(imu_status_pkg::OFS_STEP_LOW, seed[7:0], 1'h0);
      host.rd(imu_status_pkg::OFS_STEP_HIGH, seed[15:8], 1'h0);
      host.rd(imu_status_pkg::OFS_GEST_ACT, {3'h0, 2'(g), 3'(g)}, 1'h0);
    end
    $display("test results done");
    for (int m = 0; m < 8; m++) begin
      @(posedge i_clk);
      msg <= 4'(m);
      mv <= 1'h1;
      @(posedge i_clk);
      mv <= 1'h0;
      host.rd(imu_status_pkg::OFS_INTERNAL, 8'(m), 1'h0);
    end
    n50 <= 1'h1;
    host.wr(imu_status_pkg::OFS_REMAP, 8'h20);
    host.rd(imu_status_pkg::OFS_INTERNAL, 8'h27, 1'h0);
    host.wr(imu_status_pkg::OFS_RATE_CFG, 8'h04);
    host.rd(imu_status_pkg::OFS_INTERNAL, 8'h67, 1'h0);
    host.wr(imu_status_pkg::OFS_REMAP, 8'h24);
    host.rd(imu_status_pkg::OFS_INTERNAL, 8'h47, 1'h0);
    host.wr(imu_status_pkg::OFS_RATE_CFG, 8'h05);
    host.rd(imu_status_pkg::OFS_INTERNAL, 8'h07, 1'h0);
    host.rd(imu_status_pkg::OFS_REMAP, 8'h24, 1'h0);
    host.rd(imu_status_pkg::OFS_RATE_CFG, 8'h05, 1'h0);
    stop <= 1'h1;
    repeat (6) @(posedge i_clk);
    host.rd(imu_status_pkg::OFS_INTERNAL, 8'h04, 1'h0);
    stop <= 1'h0;
    $display("test internal status done");
    host.wr(imu_status_pkg::OFS_IRQ_ENABLE, 8'h00);
    host.wr(imu_status_pkg::OFS_IRQ_CLEAR, 8'h03);
    pulse_evt(7'h01, 6'h00);
    chk_irq(1'h0);
    host.wr(imu_status_pkg::OFS_IRQ_ENABLE, 8'h01);
    chk_irq(1'h1);
    host.rd(imu_status_pkg::OFS_IRQ_STATUS, 8'h01, 1'h0);
    host.wr(imu_status_pkg::OFS_IRQ_CLEAR, 8'h01);
    chk_irq(1'h0);
    pulse_evt(7'h00, 6'h04);
    chk_irq(1'h0);
    host.wr(imu_status_pkg::OFS_IRQ_ENABLE, 8'h03);
    chk_irq(1'h1);
    host.rd(imu_status_pkg::OFS_IRQ_STATUS, 8'h02, 1'h0);
    host.rd(imu_status_pkg::OFS_IRQ_ENABLE, 8'h03, 1'h0);
    host.rd(imu_status_pkg::OFS_IRQ_CLEAR, 8'h00, 1'h0);
    host.wr(imu_status_pkg::OFS_IRQ_CLEAR, 8'h02);
    chk_irq(1'h0);
    $display("test interrupt done");
    repeat (3) @(posedge i_clk);
    summarize();
  end
endmodule
`default_nettype wire
